//--- hdl/rsl_pkg.sv
// package: register map, field layout and carrier types of the receive slip / loopback irq block
package rsl_pkg;

    // register byte offsets (word aligned)
    localparam logic [7:0] RSL_OFS_SLIP_EN = 8'h00; // slip_buffer_irq_enable
    localparam logic [7:0] RSL_OFS_SLIP_STAT = 8'h04; // slip status, clear on read
    localparam logic [7:0] RSL_OFS_LB_STAT = 8'h08; // loopback_code_irq_status
    localparam logic [7:0] RSL_OFS_LB_EN = 8'h0C; // loopback change irq enable
    localparam logic [7:0] RSL_OFS_DET_CTRL = 8'h10; // activation detection enable
    localparam logic [7:0] RSL_OFS_PATTERN = 8'h14; // activation_code_pattern
    localparam int RSL_ADDR_W = 8;

    // slip enable / slip status field positions
    localparam int RSL_BIT_FULL = 2;
    localparam int RSL_BIT_EMPTY = 1;
    localparam int RSL_BIT_SLIP = 0;
    // loopback status / enable and detection control field positions
    localparam int RSL_BIT_ACT_SEEN = 3;
    localparam int RSL_BIT_ACT_CHG = 1;
    localparam int RSL_BIT_DET_EN = 0;

    // sticky status flags, in index order
    localparam int RSL_NUM_FLAGS = 4;
    localparam int RSL_FLAG_SLIP = 0;
    localparam int RSL_FLAG_EMPTY = 1;
    localparam int RSL_FLAG_FULL = 2;
    localparam int RSL_FLAG_ACT = 3;

    // reset values
    localparam logic [2:0] RSL_RST_SLIP_EN = 3'h0;
    localparam logic RSL_RST_BIT = 1'h0;
    localparam logic [31:0] RSL_RST_WORD = 32'h0000_0000;

    // ahb transfer type bits and response
    localparam logic [1:0] RSL_HTRANS_NONSEQ = 2'h2;
    localparam logic RSL_HRESP_OKAY = 1'h0;

    // slip buffer activity reported by the receive slip buffer
    typedef struct packed {
        logic full;  // buffer currently full
        logic empty; // buffer currently empty
        logic wr;    // a frame write strobe this cycle
        logic rd;    // a frame read strobe this cycle
    } rsl_slip_evt_t;

    // latched ahb address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [RSL_ADDR_W-1:0] addr;
    } rsl_ahb_aph_t;

endpackage

//--- hdl/rsl_sticky.sv
// sticky status flag: set by hardware, cleared by a register read, set wins
`timescale 1ns/1ps

module rsl_sticky
    import rsl_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_set,
    input wire logic i_clr,
    output logic o_flag
);

    // an event in the clearing cycle is kept
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_flag <= RSL_RST_BIT;
        end else if (i_set) begin
            o_flag <= 1'b1;
        end else if (i_clr) begin
            o_flag <= 1'b0;
        end
    end

endmodule

//--- hdl/rsl_irq.sv
// receive slip buffer and loopback activation code interrupt block with ahb-lite registers
//
// Contract
// (R1) three rw slip enables: full bit 2, empty bit 1, slip bit 0, reset 0
// (R2) full interrupt declared when the slip buffer becomes filled
// (R3) write into full buffer drops one frame and sets its status bit
// (R4) empty interrupt declared when the slip buffer becomes emptied
// (R5) read from empty buffer repeats one frame and sets its status bit
// (R6) slip interrupt on either frame drop or frame repeat
// (R7) read-only bit 3 shows live activation code detection, reset 0
// (R8) live detection reported only while detection is enabled; pattern from own register
// (R9) loopback status bits 7-4 reserved, read as zero
// (R10) slip status bits hold events since last read; reading clears them
// (R11) activation change interrupt on both start and end of detection
// (R12) interrupt request high while any set status bit has its enable set
`timescale 1ns/1ps

module rsl_irq
    import rsl_pkg::*;
#(
    parameter int PATTERN_W = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    // ahb-lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // receive slip buffer
    input wire rsl_slip_evt_t i_slip_evt,
    output logic o_rx_frame_drop,
    output logic o_rx_frame_repeat,
    // activation code matcher
    input wire logic i_act_code_match,
    output logic o_act_det_en,
    output logic [PATTERN_W-1:0] o_act_code_pattern,
    // interrupt request
    output logic o_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    rsl_ahb_aph_t aph;
    logic rx_buf_full_irq_en;
    logic rx_buf_empty_irq_en;
    logic rx_buf_slip_irq_en;
    logic activation_change_irq_en;
    logic activation_code_seen;
    logic full_q;
    logic empty_q;
    logic take;
    logic rd_take;
    logic wr_now;
    logic overflow;
    logic underflow;
    logic next_seen;
    logic [RSL_NUM_FLAGS-1:0] flag_set;
    logic [RSL_NUM_FLAGS-1:0] flag_clr;
    logic [RSL_NUM_FLAGS-1:0] flag;
    logic [RSL_NUM_FLAGS-1:0] flag_en;
    logic [31:0] next_rdata;
    logic [RSL_ADDR_W-1:0] rd_addr;
    logic wr_slip_en;
    logic wr_lb_en;
    logic wr_det_ctrl;
    logic wr_pattern;
    logic rd_slip_stat;
    logic rd_lb_stat;

    ////////////////////////////////////////////////////////////////////////////
    // ahb address phase
    assign take = i_hsel && i_hready && i_htrans[1];
    assign rd_take = take && !i_hwrite;
    assign rd_addr = i_haddr[RSL_ADDR_W-1:0];
    assign wr_now = aph.valid && aph.write;

    // data phase write strobes, one per writable register
    assign wr_slip_en = wr_now && (aph.addr == RSL_OFS_SLIP_EN);
    assign wr_lb_en = wr_now && (aph.addr == RSL_OFS_LB_EN);
    assign wr_det_ctrl = wr_now && (aph.addr == RSL_OFS_DET_CTRL);
    assign wr_pattern = wr_now && (aph.addr == RSL_OFS_PATTERN);

    // address phase reads of the clear-on-read status registers
    assign rd_slip_stat = rd_take && (rd_addr == RSL_OFS_SLIP_STAT);
    assign rd_lb_stat = rd_take && (rd_addr == RSL_OFS_LB_STAT);

    // latch the address phase for the data phase write
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            aph <= '0;
        end else if (i_hready) begin
            aph.valid <= take;
            aph.write <= i_hwrite;
            aph.addr <= i_haddr[RSL_ADDR_W-1:0];
        end
    end

    // zero wait state, ready also while in reset
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_hreadyout <= 1'b1;
        end else begin
            o_hreadyout <= 1'b1;
        end
    end

    // every transfer answers okay, unmapped ones included
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_hresp <= RSL_HRESP_OKAY;
        end else begin
            o_hresp <= RSL_HRESP_OKAY;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // writable registers

    // (R1) slip enables written
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            {rx_buf_full_irq_en, rx_buf_empty_irq_en, rx_buf_slip_irq_en} <= RSL_RST_SLIP_EN;
        end else if (wr_slip_en) begin
            rx_buf_full_irq_en <= i_hwdata[RSL_BIT_FULL];
            rx_buf_empty_irq_en <= i_hwdata[RSL_BIT_EMPTY];
            rx_buf_slip_irq_en <= i_hwdata[RSL_BIT_SLIP];
        end
    end

    // loopback change enable
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            activation_change_irq_en <= RSL_RST_BIT;
        end else if (wr_lb_en) begin
            activation_change_irq_en <= i_hwdata[RSL_BIT_ACT_CHG];
        end
    end

    // (R8) detection enable for the matcher
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_act_det_en <= RSL_RST_BIT;
        end else if (wr_det_ctrl) begin
            o_act_det_en <= i_hwdata[RSL_BIT_DET_EN];
        end
    end

    // (R8) pattern handed to the matcher
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_act_code_pattern <= '0;
        end else if (wr_pattern) begin
            o_act_code_pattern <= i_hwdata[PATTERN_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // slip buffer events
    assign overflow = i_slip_evt.wr && i_slip_evt.full;
    assign underflow = i_slip_evt.rd && i_slip_evt.empty;

    // previous buffer levels for becoming full or empty
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            full_q <= RSL_RST_BIT;
            empty_q <= RSL_RST_BIT;
        end else begin
            full_q <= i_slip_evt.full;
            empty_q <= i_slip_evt.empty;
        end
    end

    // (R3) drop a frame on overflow write
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rx_frame_drop <= RSL_RST_BIT;
        end else begin
            o_rx_frame_drop <= overflow;
        end
    end

    // (R5) repeat a frame on underflow read
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rx_frame_repeat <= RSL_RST_BIT;
        end else begin
            o_rx_frame_repeat <= underflow;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // live activation code state
    // (R8) live state gated by detection enable
    assign next_seen = o_act_det_en && i_act_code_match;

    // (R7) live detection bit
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            activation_code_seen <= RSL_RST_BIT;
        end else begin
            activation_code_seen <= next_seen;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky status flags
    always_comb begin
        flag_set = '0;
        // (R2) buffer becomes filled, or overflow
        flag_set[RSL_FLAG_FULL] = (i_slip_evt.full && !full_q) || overflow;
        // (R4) buffer becomes emptied, or underflow
        flag_set[RSL_FLAG_EMPTY] = (i_slip_evt.empty && !empty_q) || underflow;
        // (R6) either slip direction
        flag_set[RSL_FLAG_SLIP] = overflow || underflow;
        // (R11) both edges of detection
        flag_set[RSL_FLAG_ACT] = next_seen != activation_code_seen;
    end

    // (R10) read of a status register clears its flags
    always_comb begin
        flag_clr = '0;
        flag_clr[RSL_FLAG_FULL] = rd_slip_stat;
        flag_clr[RSL_FLAG_EMPTY] = rd_slip_stat;
        flag_clr[RSL_FLAG_SLIP] = rd_slip_stat;
        flag_clr[RSL_FLAG_ACT] = rd_lb_stat;
    end

    // one sticky cell per flag
    for (genvar g = 0; g < RSL_NUM_FLAGS; g++) begin : g_flag
        rsl_sticky u_sticky (
            .i_clk(i_clk),
            .i_rst_b(i_rst_b),
            .i_set(flag_set[g]),
            .i_clr(flag_clr[g]),
            .o_flag(flag[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt output
    always_comb begin
        flag_en = '0;
        flag_en[RSL_FLAG_FULL] = rx_buf_full_irq_en;
        flag_en[RSL_FLAG_EMPTY] = rx_buf_empty_irq_en;
        flag_en[RSL_FLAG_SLIP] = rx_buf_slip_irq_en;
        flag_en[RSL_FLAG_ACT] = activation_change_irq_en;
    end

    // (R12) request while an enabled flag is set
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_irq <= RSL_RST_BIT;
        end else begin
            o_irq <= |(flag & flag_en);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data, captured at the address phase so a clear never loses a value
    always_comb begin
        next_rdata = RSL_RST_WORD;
        unique case (rd_addr)
            RSL_OFS_SLIP_EN: begin
                next_rdata[RSL_BIT_FULL] = rx_buf_full_irq_en;
                next_rdata[RSL_BIT_EMPTY] = rx_buf_empty_irq_en;
                next_rdata[RSL_BIT_SLIP] = rx_buf_slip_irq_en;
            end
            RSL_OFS_SLIP_STAT: begin
                next_rdata[RSL_BIT_FULL] = flag[RSL_FLAG_FULL];
                next_rdata[RSL_BIT_EMPTY] = flag[RSL_FLAG_EMPTY];
                next_rdata[RSL_BIT_SLIP] = flag[RSL_FLAG_SLIP];
            end
            // (R9) bits 7-4 left at zero
            RSL_OFS_LB_STAT: begin
                next_rdata[RSL_BIT_ACT_SEEN] = activation_code_seen;
                next_rdata[RSL_BIT_ACT_CHG] = flag[RSL_FLAG_ACT];
            end
            RSL_OFS_LB_EN: begin
                next_rdata[RSL_BIT_ACT_CHG] = activation_change_irq_en;
            end
            RSL_OFS_DET_CTRL: begin
                next_rdata[RSL_BIT_DET_EN] = o_act_det_en;
            end
            RSL_OFS_PATTERN: begin
                next_rdata[PATTERN_W-1:0] = o_act_code_pattern;
            end
            default: begin
                next_rdata = RSL_RST_WORD; // unmapped reads as zero
            end
        endcase
    end

    // read data register
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_hrdata <= RSL_RST_WORD;
        end else if (rd_take) begin
            o_hrdata <= next_rdata;
        end
    end

endmodule

//--- verif/rsl_irq_assertions.sv
// port-level assertion checker for the slip / loopback interrupt block
`timescale 1ns/1ps
module rsl_irq_assertions
    import rsl_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic i_hready,
    input wire rsl_slip_evt_t i_slip_evt,
    input wire logic i_act_code_match,
    input wire logic [31:0] o_hrdata,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    input wire logic o_rx_frame_drop,
    input wire logic o_rx_frame_repeat,
    input wire logic o_act_det_en,
    input wire logic o_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    logic acc;
    logic lb_rd;
    // accepted transfer and loopback status read
    assign acc = i_hsel && i_hready && i_htrans[1];
    assign lb_rd = acc && !i_hwrite && (i_haddr[7:0] == RSL_OFS_LB_STAT);
    ////////////////////////////////////////////////////////////////////////
    property p_drop;
        i_slip_evt.wr && i_slip_evt.full |=> o_rx_frame_drop;
    endproperty
    a_drop: assert property (p_drop) else $error("no frame drop on overflow");
    property p_no_drop;
        !(i_slip_evt.wr && i_slip_evt.full) |=> !o_rx_frame_drop;
    endproperty
    a_no_drop: assert property (p_no_drop) else $error("stray frame drop");
    property p_repeat;
        i_slip_evt.rd && i_slip_evt.empty |=> o_rx_frame_repeat;
    endproperty
    a_repeat: assert property (p_repeat) else $error("no frame repeat");
    property p_no_repeat;
        !(i_slip_evt.rd && i_slip_evt.empty) |=> !o_rx_frame_repeat;
    endproperty
    a_no_repeat: assert property (p_no_repeat) else $error("stray frame repeat");
    property p_lb_resv;
        lb_rd |=> o_hrdata[7:4] == 4'h0 && o_hrdata[2] == 1'h0;
    endproperty
    a_lb_resv: assert property (p_lb_resv) else $error("reserved bits set");
    property p_seen;
        lb_rd |=> o_hrdata[RSL_BIT_ACT_SEEN] == $past(o_act_det_en && i_act_code_match, 2);
    endproperty
    a_seen: assert property (p_seen) else $error("live seen bit wrong");
    property p_bus_ok;
        o_hreadyout && o_hresp == RSL_HRESP_OKAY;
    endproperty
    a_bus_ok: assert property (p_bus_ok) else $error("bus wait or error");
    property p_irq_fall;
        $fell(o_irq) |-> $past(acc, 2) || $past(acc, 3);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell uncaused");
endmodule

//--- verif/tb_rsl_irq.sv
// self-checking testbench for the slip / loopback interrupt block
`timescale 1ns/1ps
module tb_rsl_irq;
    import rsl_pkg::*;
    logic i_clk, i_rst_b, i_hsel, i_hwrite, i_act_code_match;
    logic [31:0] i_haddr, i_hwdata, o_hrdata;
    logic [1:0] i_htrans;
    logic [2:0] i_hsize;
    rsl_slip_evt_t i_slip_evt;
    logic o_hreadyout, o_hresp, o_rx_frame_drop, o_rx_frame_repeat, o_act_det_en, o_irq;
    logic [7:0] o_act_code_pattern;
    int fail_count = 0;
    int tests_run = 0;
    rsl_irq u_rsl_irq (.i_clk, .i_rst_b, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
        .i_hsize, .i_hwdata, .i_hready(o_hreadyout), .o_hrdata, .o_hreadyout, .o_hresp,
        .i_slip_evt, .o_rx_frame_drop, .o_rx_frame_repeat, .i_act_code_match,
        .o_act_det_en, .o_act_code_pattern, .o_irq);
    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (fail_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one single ahb transfer, entered just after a rising edge
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
            output logic [31:0] rd);
        i_htrans <= RSL_HTRANS_NONSEQ;
        i_haddr <= {24'h0, a};
        i_hwrite <= w;
        do @(posedge i_clk); while (o_hreadyout !== 1'h1);
        i_htrans <= 2'h0;
        i_hwdata <= wd;
        do @(posedge i_clk); while (o_hreadyout !== 1'h1);
        rd = o_hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] d;
        xfer(a, 1'h1, v, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        xfer(a, 1'h0, 32'h0, d);
        chk(d, exp);
    endtask
    // one-cycle slip buffer event, then let flag and irq settle
    task automatic slip_pulse(input rsl_slip_evt_t e);
        i_slip_evt <= e;
        @(posedge i_clk);
        i_slip_evt <= 4'h0;
        repeat (3) @(posedge i_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd_chk(RSL_OFS_SLIP_EN, 32'h0);
        rd_chk(RSL_OFS_SLIP_STAT, 32'h0);
        rd_chk(RSL_OFS_LB_STAT, 32'h0);
        rd_chk(8'h40, 32'h0);
        chk({31'h0, o_irq}, 32'h0);
    endtask
    task automatic t_regs();
        wr(RSL_OFS_SLIP_EN, 32'hFFFF_FFFF);
        rd_chk(RSL_OFS_SLIP_EN, 32'h7);
        wr(RSL_OFS_PATTERN, 32'hA5);
        rd_chk(RSL_OFS_PATTERN, 32'hA5);
        chk({24'h0, o_act_code_pattern}, 32'hA5);
    endtask
    task automatic t_overflow();
        slip_pulse(4'hA);
        chk({31'h0, o_irq}, 32'h1);
        rd_chk(RSL_OFS_SLIP_STAT, 32'h5);
        rd_chk(RSL_OFS_SLIP_STAT, 32'h0);
        chk({31'h0, o_irq}, 32'h0);
    endtask
    task automatic t_underflow();
        wr(RSL_OFS_SLIP_EN, 32'h0);
        slip_pulse(4'h5);
        chk({31'h0, o_irq}, 32'h0);
        rd_chk(RSL_OFS_SLIP_STAT, 32'h3);
        slip_pulse(4'h8);
        rd_chk(RSL_OFS_SLIP_STAT, 32'h4);
    endtask
    task automatic t_activation();
        i_act_code_match <= 1'h1;
        repeat (3) @(posedge i_clk);
        rd_chk(RSL_OFS_LB_STAT, 32'h0);
        wr(RSL_OFS_LB_EN, 32'h2);
        wr(RSL_OFS_DET_CTRL, 32'h1);
        repeat (3) @(posedge i_clk);
        chk({31'h0, o_irq}, 32'h1);
        chk({31'h0, o_act_det_en}, 32'h1);
        rd_chk(RSL_OFS_LB_STAT, 32'hA);
        rd_chk(RSL_OFS_LB_STAT, 32'h8);
        i_act_code_match <= 1'h0;
        repeat (3) @(posedge i_clk);
        rd_chk(RSL_OFS_LB_STAT, 32'h2);
        rd_chk(RSL_OFS_LB_STAT, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // clock generator
    initial begin
        i_clk = 1'h0;
        forever #25 i_clk = ~i_clk;
    end
    // watchdog against a hung handshake
    initial begin
        repeat (3000) @(posedge i_clk);
        fail_count++;
        summarize();
    end
    // main sequence
    initial begin
        i_rst_b <= 1'h0;
        i_hsel <= 1'h1;
        i_haddr <= 32'h0;
        i_htrans <= 2'h0;
        i_hwrite <= 1'h0;
        i_hsize <= 3'h2;
        i_hwdata <= 32'h0;
        i_slip_evt <= 4'h0;
        i_act_code_match <= 1'h0;
        repeat (6) @(posedge i_clk);
        i_rst_b <= 1'h1;
        @(posedge i_clk);
        t_reset();
        t_regs();
        t_overflow();
        t_underflow();
        t_activation();
        summarize();
    end
endmodule
bind rsl_irq rsl_irq_assertions u_rsl_irq_assertions (.i_clk, .i_rst_b, .i_hsel,
    .i_haddr, .i_htrans, .i_hwrite, .i_hready, .i_slip_evt, .i_act_code_match, .o_hrdata,
    .o_hreadyout, .o_hresp, .o_rx_frame_drop, .o_rx_frame_repeat, .o_act_det_en, .o_irq);
